/* include/csl_pkg.sv */
// Purpose: Shared constants and carriers for the configuration source loader
// Assumes: 16-bit word images on both sources, byte-wide eFuse reads
// Notes:   All word offsets are word indices into the respective image
package csl_pkg;

  // ---------------------------------------------------------------
  // Image layout
  // ---------------------------------------------------------------
  localparam logic [7:0] CSL_SCM_PID_WORD    = 8'h03;
  localparam logic [7:0] CSL_SCM_VID_WORD    = 8'h04;
  localparam logic [7:0] CSL_SCM_FLAG_WORD   = 8'h05;
  localparam logic [7:0] CSL_SCM_LAST_WORD   = 8'h42;
  localparam logic [7:0] CSL_FUSE_CSUM_WORD  = 8'h19;
  localparam int         CSL_FUSE_BYTES      = 64;
  localparam int         CSL_FUSE_WORDS      = CSL_FUSE_BYTES / 2;
  localparam logic [7:0] CSL_BLANK_BYTE      = 8'hFF;
  localparam logic [7:0] CSL_CSUM_BASE       = 8'hFF;
  localparam int         CSL_FLAG_LSB        = 8;
  localparam int         CSL_CSUM_LSB        = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CSL_CLK_MHZ         = 50;
  localparam int         CSL_SCM_SCLK_KHZ    = 1000;
  localparam int         CSL_SCM_HALF_CYC    =
    (CSL_CLK_MHZ * 1000) / (2 * CSL_SCM_SCLK_KHZ);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CSL_SRC_NONE    = 2'h0,
    CSL_SRC_SCM     = 2'h1,
    CSL_SRC_FUSE    = 2'h2,
    CSL_SRC_DEFAULT = 2'h3
  } csl_src_e;

  typedef struct packed {
    logic       req;
    logic [7:0] addr;
  } csl_rd_req_s;

  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } csl_rd_rsp_s;

  typedef struct packed {
    logic        vld;
    logic [7:0]  addr;
    logic [15:0] data;
  } csl_cfg_wr_s;

  // One's-complement style: carry out of the byte sum is folded back in
  function automatic logic [7:0] csl_scm_csum(input logic [15:0] w3, input logic [15:0] w4);
    logic [9:0] s;
    logic [8:0] f;
    s = 10'(w3[7:0]) + 10'(w3[15:8]) + 10'(w4[7:0]) + 10'(w4[15:8]);
    f = 9'(s[7:0]) + 9'(s[9:8]);
    f = 9'(f[7:0]) + 9'(f[8]);
    return CSL_CSUM_BASE - f[7:0];
  endfunction

endpackage

/* hw/csl_scm_rd.sv */
// Purpose: Microwire-style word reader for the serial configuration memory
// Assumes: 8-bit word address, read opcode 110, 16-bit data MSB first
// Notes:   One word per request; ack is a one-cycle pulse with data
`timescale 1ns/1ps
module csl_scm_rd
  import csl_pkg::*;
#(
  parameter int HALF_CYC = CSL_SCM_HALF_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire csl_rd_req_s i_req,
  output csl_rd_rsp_s      o_rsp,
  output logic             o_cs,
  output logic             o_sk,
  output logic             o_di,
  input  wire logic        i_do
);

  initial begin
    if (HALF_CYC < 1 || HALF_CYC > 65536) $error("HALF_CYC must fit the 16-bit divider");
  end

  localparam int NBITS = 3 + 8 + 16;

  logic [15:0] div_r;
  logic [5:0]  bit_r;
  logic        busy_r;
  logic [10:0] sh_r;
  logic [15:0] dat_r;

  // ---------------------------------------------------------------
  // Serial shifter: command out on falling, data sampled on rising
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r  <= 16'h0000;
      bit_r  <= 6'h00;
      busy_r <= 1'b0;
      sh_r   <= 11'h000;
      dat_r  <= 16'h0000;
      o_cs   <= 1'b0;
      o_sk   <= 1'b0;
      o_di   <= 1'b0;
      o_rsp  <= '0;
    end else begin
      o_rsp.ack <= 1'b0;
      if (!busy_r) begin
        if (i_req.req) begin
          busy_r <= 1'b1;
          o_cs   <= 1'b1;
          // Opcode MSB goes out with select so it has settled before the first rise
          o_di   <= 1'b1;
          sh_r   <= {2'b10, i_req.addr, 1'b0};
          bit_r  <= 6'h00;
          div_r  <= 16'h0000;
        end
      end else if (div_r == 16'(HALF_CYC - 1)) begin
        div_r <= 16'h0000;
        o_sk  <= ~o_sk;
        if (!o_sk) begin
          if (bit_r >= 6'd11) begin
            dat_r <= {dat_r[14:0], i_do};
          end
        end else begin
          bit_r <= bit_r + 6'h01;
          if (bit_r == 6'(NBITS - 1)) begin
            busy_r     <= 1'b0;
            o_cs       <= 1'b0;
            o_rsp.ack  <= 1'b1;
            o_rsp.data <= dat_r;
          end
        end
        // Data moves on the fall so the memory never samples it mid-change
        if (o_sk) begin
          o_di <= sh_r[10];
          sh_r <= {sh_r[9:0], 1'b0};
        end
      end else begin
        div_r <= div_r + 16'h0001;
      end
    end
  end

endmodule

/* hw/csl_loader.sv */
// Purpose: Power-on configuration loader choosing memory, fuse or defaults
// Assumes: Fuse array is read by a one-cycle byte port
// Notes:   Writes each loaded word to o_cfg; o_done rises after the last write and qualifies o_src, o_flag and o_led_mode_lo
//
// Summary of operation
// R1: After every reset, fetch configuration from memory or fuse without host help.
// R2: Use serial memory first when word 05h low byte equals FF minus sum.
// R3: On memory checksum failure, go on to evaluate the fuse array.
// R4: Fuse is valid only if byte 0 is not FF and its checksum matches.
// R5: On fuse checksum failure, apply built-in default configuration.
// R6: Fuse store offers 64 user-programmable bytes.
// R7: External active-low reset acts like power-on and restarts loading.
// R8: Carry from the word 03h-04h byte sum is added back before comparing.
// R9: Word 05h high byte is the flag, low byte the checksum.
// R10: Fuse word 19h low byte is checksum, high byte is low LED mode.
// R11: Raise done once a source or defaults are loaded.
`timescale 1ns/1ps
module csl_loader
  import csl_pkg::*;
#(
  parameter int          FUSE_BYTES   = CSL_FUSE_BYTES,
  parameter int          SCM_HALF_CYC = CSL_SCM_HALF_CYC,
  parameter logic [15:0] DEF_WORD     = 16'h0000
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  output logic             o_scm_cs,
  output logic             o_scm_sk,
  output logic             o_scm_di,
  input  wire logic        i_scm_do,
  output logic [5:0]       o_fuse_addr,
  input  wire logic [7:0]  i_fuse_data,
  output csl_cfg_wr_s      o_cfg,
  output csl_src_e         o_src,
  output logic [7:0]       o_flag,
  output logic [7:0]       o_led_mode_lo,
  output logic             o_done
);

  initial begin
    if (FUSE_BYTES != CSL_FUSE_BYTES) $error("Fuse array must be 64 bytes"); // see R6
  end

  typedef enum logic [7:0] {
    S_RST   = 8'h01,
    S_SCMCK = 8'h02,
    S_SCMLD = 8'h04,
    S_FUSCK = 8'h08,
    S_FUSLD = 8'h10,
    S_DEF   = 8'h20,
    S_DONE  = 8'h40
  } csl_st_e;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rs1_r;
  logic rst_n;

  // Pin reset and power-on share this path, so either restarts loading
  always_ff @(posedge i_clk or negedge i_rst_n) begin // see R7
    if (!i_rst_n) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  // ---------------------------------------------------------------
  // Serial memory reader
  // ---------------------------------------------------------------
  csl_rd_req_s rd_req;
  csl_rd_rsp_s rd_rsp;

  csl_scm_rd #(
    .HALF_CYC (SCM_HALF_CYC)
  ) u_rd (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_req   (rd_req),
    .o_rsp   (rd_rsp),
    .o_cs    (o_scm_cs),
    .o_sk    (o_scm_sk),
    .o_di    (o_scm_di),
    .i_do    (i_scm_do)
  );

  csl_st_e     st_r;
  logic [7:0]  idx_r;
  logic        pend_r;
  logic [15:0] w3_r;
  logic [15:0] w4_r;
  logic [7:0]  fw_r;
  logic        half_r;
  logic [7:0]  fsum_r;
  logic [7:0]  fuse0_r;

  // Fuse checksum: byte sum of all bytes before the checksum byte, folded
  function automatic logic [7:0] fold_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = 9'(a) + 9'(b);
    return s[7:0] + 8'(s[8]);
  endfunction

  assign rd_req.req  = pend_r;
  assign rd_req.addr = idx_r;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= S_RST;
      idx_r         <= 8'h00;
      pend_r        <= 1'b0;
      w3_r          <= 16'h0000;
      w4_r          <= 16'h0000;
      fw_r          <= 8'h00;
      half_r        <= 1'b0;
      fsum_r        <= 8'h00;
      fuse0_r       <= 8'h00;
      o_fuse_addr   <= 6'h00;
      o_cfg         <= '0;
      o_src         <= CSL_SRC_NONE;
      o_flag        <= 8'h00;
      o_led_mode_lo <= 8'h00;
      o_done        <= 1'b0;
    end else begin
      pend_r    <= 1'b0;
      o_cfg.vld <= 1'b0;
      case (st_r)
        S_RST: begin // see R1
          st_r   <= S_SCMCK;
          idx_r  <= CSL_SCM_PID_WORD;
          pend_r <= 1'b1;
        end
        S_SCMCK: begin
          if (rd_rsp.ack) begin
            if (idx_r == CSL_SCM_PID_WORD) begin
              w3_r   <= rd_rsp.data;
              idx_r  <= CSL_SCM_VID_WORD;
              pend_r <= 1'b1;
            end else if (idx_r == CSL_SCM_VID_WORD) begin
              w4_r   <= rd_rsp.data;
              idx_r  <= CSL_SCM_FLAG_WORD;
              pend_r <= 1'b1;
            end else if (rd_rsp.data[CSL_CSUM_LSB +: 8] == csl_scm_csum(w3_r, w4_r)) begin
              // see R2, R8, R9
              o_flag <= rd_rsp.data[CSL_FLAG_LSB +: 8];
              o_src  <= CSL_SRC_SCM;
              idx_r  <= 8'h00;
              pend_r <= 1'b1;
              st_r   <= S_SCMLD;
            end else begin
              st_r        <= S_FUSCK; // see R3
              // Address 0 has stood since reset, so byte 0 is already on the port
              o_fuse_addr <= 6'h01;
              idx_r       <= 8'h00;
              half_r      <= 1'b0;
              fsum_r      <= 8'h00;
            end
          end
        end
        S_SCMLD: begin
          if (rd_rsp.ack) begin
            o_cfg <= '{vld: 1'b1, addr: idx_r, data: rd_rsp.data};
            if (idx_r == CSL_SCM_LAST_WORD) begin
              st_r <= S_DONE;
            end else begin
              idx_r  <= idx_r + 8'h01;
              pend_r <= 1'b1;
            end
          end
        end
        S_FUSCK: begin
          // Port data lags its address by one edge, so the address runs one byte ahead
          o_fuse_addr <= o_fuse_addr + 6'h01;
          half_r      <= ~half_r;
          if (idx_r == 8'h00 && !half_r) begin
            fuse0_r <= i_fuse_data;
          end
          if (idx_r == CSL_FUSE_CSUM_WORD) begin
            if (!half_r) begin
              // Checksum byte is kept apart so the running sum stays intact
              fw_r        <= i_fuse_data;
              // Rewind one byte early so byte 0 is on the port when loading starts
              o_fuse_addr <= 6'h00;
            end else begin
              o_led_mode_lo <= i_fuse_data; // see R10
              if (fuse0_r != CSL_BLANK_BYTE && fw_r == (CSL_CSUM_BASE - fsum_r)) begin
                st_r <= S_FUSLD; // see R4
              end else begin
                st_r <= S_DEF; // see R5
              end
              o_fuse_addr <= 6'h01;
              idx_r       <= 8'h00;
              half_r      <= 1'b0;
            end
          end else begin
            if (half_r) begin
              idx_r <= idx_r + 8'h01;
            end
            fsum_r <= fold_add(fsum_r, i_fuse_data);
          end
        end
        S_FUSLD: begin
          o_src       <= CSL_SRC_FUSE;
          o_fuse_addr <= o_fuse_addr + 6'h01;
          half_r      <= ~half_r;
          if (!half_r) begin
            fw_r <= i_fuse_data;
          end else begin
            o_cfg <= '{vld: 1'b1, addr: idx_r, data: {i_fuse_data, fw_r}}; // see R6
            if (idx_r == 8'(CSL_FUSE_WORDS - 1)) begin
              st_r <= S_DONE;
            end
            idx_r <= idx_r + 8'h01;
          end
        end
        S_DEF: begin
          o_src <= CSL_SRC_DEFAULT;
          o_cfg <= '{vld: 1'b1, addr: 8'h00, data: DEF_WORD};
          st_r  <= S_DONE;
        end
        S_DONE: begin
          o_done <= 1'b1; // see R11
        end
        default: st_r <= S_RST;
      endcase
    end
  end

endmodule

/* verif/csl_loader_asserts.sv */
// Purpose: Port-level checks on the loader top
// Assumes: One clock domain, async active-low reset
// Notes:   Bound onto csl_loader from the bench
`timescale 1ns/1ps
module csl_loader_asserts
  import csl_pkg::*;
#(
  parameter int HALF_CYC = CSL_SCM_HALF_CYC
) (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        o_scm_cs,
  input wire logic        o_scm_sk,
  input wire logic        o_scm_di,
  input wire csl_cfg_wr_s o_cfg,
  input wire csl_src_e    o_src,
  input wire logic        o_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic       sk_q_r;
  logic [5:0] hi_r;
  logic [4:0] bits_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sk_q_r <= 1'b0;
      hi_r   <= 6'h00;
      bits_r <= 5'h00;
    end else begin
      sk_q_r <= o_scm_sk;
      hi_r   <= o_scm_sk ? hi_r + 6'h01 : 6'h00;
      bits_r <= !o_scm_cs ? 5'h00 : bits_r + 5'(o_scm_sk && !sk_q_r);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_bit(int n); $rose(o_scm_sk) && bits_r == 5'(n); endsequence
  sequence s_frame_end; $fell(o_scm_cs); endsequence
  property p_done_hold; o_done |=> o_done; endproperty
  property p_src_hold; o_done |=> $stable(o_src); endproperty
  property p_done_src; o_done |-> o_src != CSL_SRC_NONE; endproperty
  property p_quiet; o_done |=> !o_cfg.vld && !o_scm_cs; endproperty
  property p_sk_half; $fell(o_scm_sk) && o_scm_cs |-> hi_r == 6'(HALF_CYC); endproperty
  property p_op_one; s_bit(0) or s_bit(1) |-> o_scm_di; endproperty
  property p_op_zero; s_bit(2) |-> !o_scm_di; endproperty
  property p_frame; s_frame_end |-> bits_r == 5'h1B; endproperty
  property p_autostart; $rose(i_rst_n) |-> ##[1:80] o_scm_cs; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped");
  a_src_hold: assert property (p_src_hold) else $error("source moved");
  a_done_src: assert property (p_done_src) else $error("done, no source");
  a_quiet: assert property (p_quiet) else $error("traffic after done");
  a_sk_half: assert property (p_sk_half) else $error("bad sk high time");
  a_op_one: assert property (p_op_one) else $error("opcode bit low");
  a_op_zero: assert property (p_op_zero) else $error("opcode bit high");
  a_frame: assert property (p_frame) else $error("bad frame length");
  a_autostart: assert property (p_autostart) else $error("no self start");
endmodule

/* verif/csl_mem_model.sv */
// Purpose: Serial config memory and fuse array model
// Assumes: Opcode 110, 8-bit address, data MSB first
// Notes:   Bench fills mem and fuse directly
`timescale 1ns/1ps
module csl_mem_model (
  input  wire logic       i_clk,
  input  wire logic       i_cs,
  input  wire logic       i_sk,
  input  wire logic       i_di,
  output logic            o_do,
  input  wire logic [5:0] i_addr,
  output logic [7:0]      o_data
);
  logic [15:0] mem [256];
  logic [7:0]  fuse [64];
  logic [10:0] cmd;
  int          cnt;
  initial begin
    o_do   = 1'b0;
    o_data = 8'h00;
    cnt    = 0;
  end
  always @(posedge i_cs) cnt = 0;
  // Released line shows junk so a late sample cannot pass
  always @(negedge i_cs) o_do = ~o_do;
  always @(posedge i_sk) begin
    if (i_cs) begin
      if (cnt < 11) cmd = {cmd[9:0], i_di};
      cnt = cnt + 1;
    end
  end
  // A wrong opcode reads back inverted data
  always @(negedge i_sk) begin
    if (i_cs && cnt >= 11 && cnt < 27) o_do = mem[cmd[7:0]][26-cnt] ^ (cmd[10:8] != 3'h6);
  end
  always @(posedge i_clk) o_data <= fuse[i_addr];
endmodule

/* verif/tb.sv */
// Purpose: Self-checking bench for the configuration loader
// Assumes: Partner model holds both images
// Notes:   The memory-good case is long, so sk is scaled down at the top
`timescale 1ns/1ps
module tb;
  import csl_pkg::*;
  typedef struct packed {
    logic       mok;
    logic       b0ok;
    logic       fok;
    csl_src_e   src;
    logic [7:0] words;
  } csl_row_s;
  localparam csl_row_s ROWS [4] = '{
    '{1'b1, 1'b1, 1'b1, CSL_SRC_SCM, 8'h43},
    '{1'b0, 1'b1, 1'b1, CSL_SRC_FUSE, 8'h20},
    '{1'b0, 1'b0, 1'b1, CSL_SRC_DEFAULT, 8'h01},
    '{1'b0, 1'b1, 1'b0, CSL_SRC_DEFAULT, 8'h01}};
  logic        i_clk, i_rst_n, cs, sk, di, sdo, done;
  logic [5:0]  faddr;
  logic [7:0]  fdata, flag, led;
  csl_cfg_wr_s cfg;
  csl_src_e    src, exp_src;
  int          n_fail, total_checks, n_words;
  // Faster serial clock keeps the 67-word memory case short
  localparam int SK_HALF = 8;
  csl_loader #(.SCM_HALF_CYC(SK_HALF)) csl_loader_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .o_scm_cs(cs), .o_scm_sk(sk),
    .o_scm_di(di), .i_scm_do(sdo), .o_fuse_addr(faddr), .i_fuse_data(fdata), .o_cfg(cfg),
    .o_src(src), .o_flag(flag), .o_led_mode_lo(led), .o_done(done));
  csl_mem_model csl_mem_model_i (.i_clk(i_clk), .i_cs(cs), .i_sk(sk), .i_di(di),
    .o_do(sdo), .i_addr(faddr), .o_data(fdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] fold(input int s);
    while (s > 255) s = (s & 255) + (s >> 8);
    return 8'hFF - 8'(s);
  endfunction
  function automatic logic [15:0] exp_word(input logic [7:0] a);
    case (exp_src)
      CSL_SRC_SCM:  return csl_mem_model_i.mem[a];
      CSL_SRC_FUSE: return {csl_mem_model_i.fuse[2*a+1], csl_mem_model_i.fuse[2*a]};
      default:      return 16'h0000;
    endcase
  endfunction
  task automatic load(input csl_row_s r);
    int s;
    s = 0;
    for (int i = 0; i < 256; i++) csl_mem_model_i.mem[i] = 16'(i * 16'h0103);
    csl_mem_model_i.mem[3] = 16'hF080;
    csl_mem_model_i.mem[4] = 16'h3040;
    // Byte sum 1E0 carries past FF, so the fold matters
    csl_mem_model_i.mem[5] = {8'h5A, fold(32'h1E0) + 8'(!r.mok)};
    for (int i = 0; i < 64; i++) begin
      csl_mem_model_i.fuse[i] = (i == 0 && !r.b0ok) ? 8'hFF : 8'(i + 1);
      if (i < 50) s += csl_mem_model_i.fuse[i];
    end
    csl_mem_model_i.fuse[50] = fold(s) + 8'(!r.fok);
    csl_mem_model_i.fuse[51] = 8'hA5;
  endtask
  task automatic run(input csl_row_s r);
    load(r);
    exp_src = r.src;
    i_rst_n = 1'b0;
    repeat (6) @(negedge i_clk);
    n_words = 0;
    i_rst_n = 1'b1;
    for (int k = 0; k < 40000 && done !== 1'b1; k++) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
    check(16'(done), 16'h0001);
    check(16'(src), 16'(r.src));
    check(16'(n_words), 16'(r.words));
    if (r.src == CSL_SRC_SCM) check(16'(flag), 16'h005A);
    if (r.src == CSL_SRC_FUSE) check(16'(led), 16'h00A5);
  endtask
  always @(negedge i_clk) begin
    if (i_rst_n && cfg.vld === 1'b1) begin
      check(cfg.data, exp_word(cfg.addr));
      n_words++;
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // About 37k cycles are expected; the limit leaves twice that
  initial begin
    #(80000 * 20);
    n_fail++;
    summarize();
  end
  initial begin
    i_rst_n = 1'b0;
    @(negedge i_clk);
    foreach (ROWS[i]) run(ROWS[i]);
    // Reset in mid-read must clear outputs and restart
    i_rst_n = 1'b0;
    @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (600) @(negedge i_clk);
    check(16'(cs), 16'h0001);
    i_rst_n = 1'b0;
    @(negedge i_clk);
    check({done, cs, 14'(src)}, 16'h0000);
    run(ROWS[1]);
    summarize();
  end
endmodule
bind csl_loader csl_loader_asserts #(.HALF_CYC(SCM_HALF_CYC)) csl_loader_asserts_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n),
  .o_scm_cs(o_scm_cs), .o_scm_sk(o_scm_sk), .o_scm_di(o_scm_di), .o_cfg(o_cfg),
  .o_src(o_src), .o_done(o_done));
